// [rtl/mpx_idle_ctrl.sv]
// Purpose: multiplexed address/data cycles, byte-select SRAM reads and writes, inter-cycle idles
// Assumes: requests and register port on clock; data, wait and boot pins asynchronous
// Notes: all bus pin changes happen on ticks of the divided bus clock output
module mpx_idle_ctrl
  import mpx_idle_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire bus_req_t req,
  output logic req_ready,
  input wire logic [31:0] wdata,
  output logic beat_done,
  output logic [31:0] rdata,
  output logic rdata_valid,
  output logic access_done,
  input wire logic bus_release_req,
  output logic bus_granted,
  input wire logic boot_area0_mux_select_pin,
  input wire logic wait_req_n,
  output logic bus_clock_output,
  output logic [25:0] addr_pins,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic data_oe,
  output logic bus_cycle_start_strobe_n,
  output logic [6:0] area_select_strobe_n,
  output logic frame_n,
  output logic read_strobe_n,
  output logic [1:0] byte_strobe_n,
  output logic rd_wr
);

  logic [31:0] bus_control_one_q;
  logic [31:0] bus_control_three_q;
  logic [31:0] idle_wait_control_q;
  logic [31:0] area_wait_control_q;
  logic boot_meta_q, boot_sync_q, wait_meta_q, wait_sync_q;
  logic [31:0] din_meta_q, din_sync_q;
  logic boot_taken_q, area0_mux_q;
  logic [2:0] div_q;
  logic rise_tick, fall_tick;
  bus_state_t state_q;
  bus_req_t cur_q;
  logic [4:0] beats_left_q;
  logic [3:0] beat_idx_q;
  logic [3:0] wait_cnt_q;
  logic prev_valid_q, prev_write_q;
  logic [2:0] prev_area_q;
  logic [3:0] elapsed_q;
  logic [6:0] mux_area;
  logic [6:0] bsel_area;
  logic [3:0] owed_idle;
  logic [3:0] gap_left;
  logic [3:0] release_owed;
  logic gap_needed;
  logic p_valid, p_write;
  logic [2:0] p_area;
  logic [3:0] p_gone;
  logic launch;
  logic beat_end;
  logic last_beat;
  logic [4:0] first_beats;
  logic [3:0] next_wait;

  // Two stages on every pin input before any logic looks at it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_meta_q <= 1'b1;
      boot_sync_q <= 1'b1;
      wait_meta_q <= 1'b1;
      wait_sync_q <= 1'b1;
      din_meta_q <= 32'h0000_0000;
      din_sync_q <= 32'h0000_0000;
    end else begin
      boot_meta_q <= boot_area0_mux_select_pin;
      boot_sync_q <= boot_meta_q;
      wait_meta_q <= wait_req_n;
      wait_sync_q <= wait_meta_q;
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
    end
  end

  // Boot strap caught once after the release, when the sync chain has filled
  logic [1:0] boot_wait_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_wait_q <= 2'h0;
      boot_taken_q <= 1'b0;
      area0_mux_q <= 1'b0;
    end else if (!boot_taken_q) begin
      boot_wait_q <= boot_wait_q + 2'h1;
      if (boot_wait_q == 2'h3) begin
        boot_taken_q <= 1'b1;
        area0_mux_q <= ~boot_sync_q;
      end
    end
  end

  // Bus clock divider; pin updates land on its rising edges, byte strobes assert on its falling edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 3'h0;
      bus_clock_output <= 1'b0;
    end else if (div_q == 3'(LINK_HALF_CYCLES - 1)) begin
      div_q <= 3'h0;
      bus_clock_output <= ~bus_clock_output;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign rise_tick = (div_q == 3'(LINK_HALF_CYCLES - 1)) && !bus_clock_output;
  assign fall_tick = (div_q == 3'(LINK_HALF_CYCLES - 1)) && bus_clock_output;

  // Register port; read data appear the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_control_one_q <= BUS_CONTROL_ONE_RST;
      bus_control_three_q <= BUS_CONTROL_THREE_RST;
      idle_wait_control_q <= IDLE_WAIT_CONTROL_RST;
      area_wait_control_q <= AREA_WAIT_CONTROL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        BUS_CONTROL_ONE_OFS: bus_control_one_q <= reg_wdata;
        BUS_CONTROL_THREE_OFS: bus_control_three_q <= reg_wdata;
        IDLE_WAIT_CONTROL_OFS: idle_wait_control_q <= reg_wdata;
        AREA_WAIT_CONTROL_OFS: area_wait_control_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        BUS_CONTROL_ONE_OFS: reg_rdata <= bus_control_one_q;
        BUS_CONTROL_THREE_OFS: reg_rdata <= bus_control_three_q;
        IDLE_WAIT_CONTROL_OFS: reg_rdata <= idle_wait_control_q;
        AREA_WAIT_CONTROL_OFS: reg_rdata <= area_wait_control_q;
        STATUS_OFS: reg_rdata <= {22'h00_0000, gap_left, state_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Per-area protocol selection
  logic mode_on;
  assign mode_on = bus_control_one_q[MUX_MODE_BIT];
  assign mux_area[0] = area0_mux_q;
  generate
    for (genvar a = 1; a < 7; a++) begin : g_area
      if (a == 1) begin : g_a1
        assign mux_area[a] = mode_on && bus_control_three_q[AREA1_MUX_BIT];
        assign bsel_area[a] = bus_control_three_q[AREA1_BSEL_BIT] && !mux_area[a];
      end else if (a == 4) begin : g_a4
        assign mux_area[a] = mode_on && bus_control_three_q[AREA4_MUX_BIT];
        assign bsel_area[a] = bus_control_three_q[AREA4_BSEL_BIT] && !mux_area[a];
      end else begin : g_an
        assign mux_area[a] = mode_on && bus_control_three_q[MEM_MODE_LSB];
        assign bsel_area[a] = 1'b0;
      end
    end
  endgenerate
  assign bsel_area[0] = 1'b0;

  function automatic logic [3:0] area_field(input logic [31:0] r, input logic [2:0] n);
    logic [31:0] s;
    s = r >> (5'(n) * 5'(COUNT_FIELD_W));
    return {1'b0, s[2:0]};
  endfunction : area_field

  // Inter-cycle idle owed to the next request
  always_comb begin
    gap_needed = 1'b0;
    owed_idle = 4'h0;
    // Launch on an ending beat: that access is the previous one
    p_valid = 1'b1;
    p_write = cur_q.write;
    p_area = cur_q.area;
    p_gone = 4'h0;
    if (state_q == ST_IDLE) begin
      p_valid = prev_valid_q;
      p_write = prev_write_q;
      p_area = prev_area_q;
      p_gone = (elapsed_q == 4'hf) ? 4'hf : elapsed_q + 4'h1;
    end
    if (req.dma == DMA_SINGLE_IO_TO_MEM) begin
      owed_idle = idle_wait_control_q[DMA_IDLE_LSB +: 4];
    end else if (p_valid && !p_write) begin
      // A read buffer may still drive: turn-around or area change needs space
      gap_needed = req.write || (req.area != p_area);
      if (gap_needed) begin
        owed_idle = area_field(idle_wait_control_q, p_area);
      end
    end
    // Apart from single-address DMA into memory, writes in a row and same-area reads fall through with nothing owed
    gap_left = (owed_idle > p_gone) ? owed_idle - p_gone : 4'h0;
    release_owed = 4'h0;
    if (prev_valid_q && !prev_write_q) begin
      release_owed = area_field(idle_wait_control_q, prev_area_q);
    end
  end

  // Beats per access: 32-bit multiplexed bus or 16-bit byte-select SRAM
  always_comb begin
    first_beats = 5'h01;
    if (mux_area[req.area]) begin
      if (req.size == SIZE_QUAD) first_beats = 5'h02;
      if (req.size == SIZE_LINE) first_beats = 5'h08;
    end else begin
      case (req.size)
        SIZE_LONG: first_beats = 5'h02;
        SIZE_QUAD: first_beats = 5'h04;
        SIZE_LINE: first_beats = 5'h10;
        default: first_beats = 5'h01;
      endcase
    end
    next_wait = area_field(area_wait_control_q, cur_q.area);
  end

  assign launch = rise_tick && req_valid && (gap_left == 4'h0) && boot_taken_q &&
                  !bus_release_req && ((state_q == ST_IDLE) || (beat_end && last_beat));
  assign req_ready = launch;
  assign last_beat = (beats_left_q == 5'h01);
  // External wait pin holds off the end of any data beat
  assign beat_end = rise_tick && wait_sync_q && (wait_cnt_q == 4'h0) &&
                    ((state_q == ST_DATA) || (state_q == ST_SRAM));

  // Sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      beats_left_q <= 5'h00;
      beat_idx_q <= 4'h0;
      wait_cnt_q <= 4'h0;
    end else if (launch) begin
      cur_q <= req;
      beats_left_q <= first_beats;
      beat_idx_q <= 4'h0;
      wait_cnt_q <= 4'h0;
      state_q <= mux_area[req.area] ? ST_ADDR : ST_SRAM;
      if (!mux_area[req.area]) begin
        wait_cnt_q <= area_field(area_wait_control_q, req.area);
      end
    end else if (rise_tick) begin
      case (state_q)
        ST_IDLE: begin
          // Owed idles are served before the bus is handed over
          if (bus_release_req && (release_owed <= elapsed_q)) state_q <= ST_REL;
        end
        ST_ADDR: begin
          wait_cnt_q <= next_wait + {3'h0, ~cur_q.write};
          state_q <= (next_wait == 4'h0 && cur_q.write) ? ST_DATA : ST_WAITS;
        end
        ST_WAITS: begin
          wait_cnt_q <= wait_cnt_q - 4'h1;
          if (wait_cnt_q == 4'h1) state_q <= ST_DATA;
        end
        ST_DATA, ST_SRAM: begin
          if (wait_cnt_q != 4'h0) begin
            wait_cnt_q <= wait_cnt_q - 4'h1;
          end else if (wait_sync_q) begin
            // Burst beats follow with no release in between
            beats_left_q <= beats_left_q - 5'h01;
            beat_idx_q <= beat_idx_q + 4'h1;
            if (last_beat) state_q <= ST_IDLE;
            if (state_q == ST_SRAM) wait_cnt_q <= next_wait;
          end
        end
        ST_REL: if (!bus_release_req) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Memory of the previous access and the empty cycles since it ended
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_valid_q <= 1'b0;
      prev_write_q <= 1'b0;
      prev_area_q <= 3'h0;
      elapsed_q <= 4'h0;
    end else if (beat_end && last_beat) begin
      prev_valid_q <= 1'b1;
      prev_write_q <= cur_q.write;
      prev_area_q <= cur_q.area;
      elapsed_q <= 4'h0;
    end else if (rise_tick && (state_q == ST_IDLE) && (elapsed_q != 4'hf)) begin
      elapsed_q <= elapsed_q + 4'h1;
    end
  end

  // Beat address inside the 32-byte line, wrapping from the requested data
  logic [25:0] beat_addr;
  always_comb begin
    beat_addr = cur_q.addr;
    if (cur_q.size == SIZE_LINE || cur_q.size == SIZE_QUAD || cur_q.size == SIZE_LONG) begin
      beat_addr[4:1] = cur_q.addr[4:1] + beat_idx_q;
    end
  end

  // Bus pins, all changed on bus clock edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_cycle_start_strobe_n <= 1'b1;
      area_select_strobe_n <= 7'h7f;
      frame_n <= 1'b1;
      read_strobe_n <= 1'b1;
      byte_strobe_n <= 2'h3;
      rd_wr <= 1'b1;
      addr_pins <= 26'h000_0000;
      data_out <= 32'h0000_0000;
      data_oe <= 1'b0;
    end else if (launch) begin
      area_select_strobe_n <= ~(7'h01 << req.area);
      rd_wr <= ~req.write;
      if (mux_area[req.area]) begin
        bus_cycle_start_strobe_n <= 1'b0;
        frame_n <= 1'b0;
        data_out <= {req.size, 3'h0, req.addr};
        data_oe <= 1'b1;
        addr_pins <= 26'h000_0000;
        read_strobe_n <= 1'b1;
      end else begin
        bus_cycle_start_strobe_n <= 1'b1;
        frame_n <= 1'b1;
        addr_pins <= req.addr;
        read_strobe_n <= req.write;
        data_out <= wdata;
        data_oe <= req.write;
      end
      byte_strobe_n <= 2'h3;
    end else if (rise_tick) begin
      bus_cycle_start_strobe_n <= 1'b1;
      if (state_q == ST_ADDR) begin
        data_oe <= cur_q.write;
        data_out <= wdata;
        if (cur_q.write && next_wait == 4'h0 && beats_left_q == 5'h01) frame_n <= 1'b1;
      end
      if (state_q == ST_WAITS && wait_cnt_q == 4'h1 && beats_left_q == 5'h01) begin
        frame_n <= 1'b1;
      end
      if (beat_end) begin
        byte_strobe_n <= 2'h3;
        data_out <= wdata;
        if (beats_left_q == 5'h02) frame_n <= 1'b1;
        if (state_q == ST_SRAM) addr_pins <= beat_addr + 26'h000_0002;
        if (last_beat) begin
          // Held to the end of the last beat, no gap at minimum pitch
          area_select_strobe_n <= 7'h7f;
          read_strobe_n <= 1'b1;
          data_oe <= 1'b0;
          frame_n <= 1'b1;
        end
      end
    end else if (fall_tick && state_q == ST_SRAM && bsel_area[cur_q.area]) begin
      // Only the lanes being read or written
      if (cur_q.size == SIZE_BYTE) begin
        byte_strobe_n <= cur_q.addr[0] ? 2'h1 : 2'h2;
      end else begin
        byte_strobe_n <= 2'h0;
      end
    end
  end

  // Answers to the requester
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      beat_done <= 1'b0;
      rdata_valid <= 1'b0;
      access_done <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      beat_done <= beat_end;
      rdata_valid <= beat_end && !cur_q.write;
      access_done <= beat_end && last_beat;
      if (beat_end && !cur_q.write) rdata <= din_sync_q;
    end
  end

  assign bus_granted = (state_q == ST_REL);

endmodule : mpx_idle_ctrl

// [rtl/mpx_idle_pkg.sv]
// Purpose: constants and types for the multiplexed bus and idle wait control
// Assumes: 20 MHz system clock, bus clock output made by an even divider
// Notes: register word offsets are byte addresses on the plain register port
// Overview of operation
// - Boot pin low at reset: area 0 multiplexed
// - Areas 1-6 multiplexed by control bits
// - Address phase drives address and size code
// - Cycle start strobe lasts one bus cycle
// - Area select spans address through final transfer
// - Frame negates as last data cycle starts
// - Address pins carry nothing guaranteed when multiplexed
// - 32-byte multiplexed burst after one address
// - Programmed and external waits stretch cycles
// - Reads add one automatic wait after address
// - Byte strobes driven on reads and writes
// - Only areas 1, 4; multiplexed wins
// - Byte strobes: assert falling, negate rising
// - Byte-select 32-byte transfer wraps, holds bus
// - Remember area and direction, insert idles
// - No idles between writes or same-area reads
// - Idles owed minus empty cycles already passed
// - Finish owed idles before granting bus away
// - Single-address DMA into memory uses DMA idles
// - Dual-address DMA uses per-area idle count
package mpx_idle_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int LINK_PERIOD_NS = 400;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS / 2;

  localparam logic [7:0] BUS_CONTROL_ONE_OFS = 8'h00;
  localparam logic [7:0] BUS_CONTROL_THREE_OFS = 8'h04;
  localparam logic [7:0] IDLE_WAIT_CONTROL_OFS = 8'h08;
  localparam logic [7:0] AREA_WAIT_CONTROL_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  localparam int MUX_MODE_BIT = 0;
  localparam int MEM_MODE_LSB = 0;
  localparam int AREA1_MUX_BIT = 2;
  localparam int AREA4_MUX_BIT = 3;
  localparam int AREA1_BSEL_BIT = 4;
  localparam int AREA4_BSEL_BIT = 5;
  localparam int DMA_IDLE_LSB = 24;
  localparam int COUNT_FIELD_W = 3;

  localparam logic [31:0] BUS_CONTROL_ONE_RST = 32'h0000_0000;
  localparam logic [31:0] BUS_CONTROL_THREE_RST = 32'h0000_0000;
  localparam logic [31:0] IDLE_WAIT_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] AREA_WAIT_CONTROL_RST = 32'h0000_0000;

  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_WORD = 3'h1;
  localparam logic [2:0] SIZE_LONG = 3'h2;
  localparam logic [2:0] SIZE_QUAD = 3'h3;
  localparam logic [2:0] SIZE_LINE = 3'h4;

  typedef enum logic [1:0] {
    DMA_NONE = 2'h0,
    DMA_SINGLE_IO_TO_MEM = 2'h1,
    DMA_DUAL = 2'h2
  } dma_kind_t;

  typedef struct packed {
    logic write;
    logic [2:0] area;
    logic [2:0] size;
    logic [25:0] addr;
    dma_kind_t dma;
  } bus_req_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_WAITS = 6'h04,
    ST_DATA = 6'h08,
    ST_SRAM = 6'h10,
    ST_REL = 6'h20
  } bus_state_t;

endpackage : mpx_idle_pkg

// [tb/mpx_idle_ctrl_sva.sv]
// Purpose: pin relation checks for mpx_idle_ctrl
// Assumes: one clock domain, asynchronous active low reset
// Notes: bus pins move on bus clock rising ticks, eight system clocks apart; byte strobes assert on the falling ticks between
module mpx_idle_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic bus_release_req,
  input wire logic bus_granted,
  input wire logic [25:0] addr_pins,
  input wire logic data_oe,
  input wire logic bus_cycle_start_strobe_n,
  input wire logic [6:0] area_select_strobe_n,
  input wire logic frame_n,
  input wire logic read_strobe_n,
  input wire logic [1:0] byte_strobe_n,
  input wire logic rd_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_start_len;
    $fell(bus_cycle_start_strobe_n) |-> (!bus_cycle_start_strobe_n)[*8] ##1 bus_cycle_start_strobe_n;
  endproperty
  a_start_len: assert property (p_start_len) else $error("start strobe length wrong");
  property p_addr_phase;
    $fell(bus_cycle_start_strobe_n) |-> !frame_n && $onehot(~area_select_strobe_n) && data_oe && addr_pins == 26'h0;
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("address phase pins wrong");
  property p_frame_end;
    $rose(frame_n) |-> !(&area_select_strobe_n) && bus_cycle_start_strobe_n;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame ended outside select");
  property p_cs_end;
    $rose(&area_select_strobe_n) |-> $past(frame_n) && $past(bus_cycle_start_strobe_n);
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("select ended before frame");
  property p_frame_in_cs;
    !frame_n |-> !(&area_select_strobe_n);
  endproperty
  a_frame_in_cs: assert property (p_frame_in_cs) else $error("frame without select");
  property p_auto_wait;
    $rose(bus_cycle_start_strobe_n) && rd_wr |-> (!(&area_select_strobe_n) && !data_oe)[*8];
  endproperty
  a_auto_wait: assert property (p_auto_wait) else $error("read lacks automatic wait");
  property p_byte_neg;
    $rose(read_strobe_n) |-> byte_strobe_n == 2'b11;
  endproperty
  a_byte_neg: assert property (p_byte_neg) else $error("byte strobe outlived read strobe");
  property p_byte_in_cs;
    byte_strobe_n != 2'b11 |-> !(&area_select_strobe_n) && bus_cycle_start_strobe_n;
  endproperty
  a_byte_in_cs: assert property (p_byte_in_cs) else $error("byte strobe outside access");
  property p_release;
    bus_granted |-> &area_select_strobe_n && bus_cycle_start_strobe_n && !data_oe;
  endproperty
  a_release: assert property (p_release) else $error("pins driven while released");
  property p_ready;
    req_ready |-> req_valid && !bus_release_req && !bus_granted;
  endproperty
  a_ready: assert property (p_ready) else $error("request taken while releasing");
endmodule : mpx_idle_chk

bind mpx_idle_ctrl mpx_idle_chk chk_u (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
  .bus_release_req(bus_release_req), .bus_granted(bus_granted), .addr_pins(addr_pins), .data_oe(data_oe),
  .bus_cycle_start_strobe_n(bus_cycle_start_strobe_n), .area_select_strobe_n(area_select_strobe_n),
  .frame_n(frame_n), .read_strobe_n(read_strobe_n), .byte_strobe_n(byte_strobe_n), .rd_wr(rd_wr));

// [tb/mpx_far_model.sv]
// Purpose: far end multiplexed bus device
// Assumes: read data is size, 3'h5 and the latched address
// Notes: released data lines toggle, so stale values never match by luck
module mpx_far_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [31:0] data_out,
  input wire logic data_oe,
  input wire logic bs_n,
  input wire logic [6:0] cs_n,
  input wire logic rd_wr,
  input wire logic stall,
  output logic [31:0] data_in,
  output logic wait_req_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [25:0] addr_q;
  logic [2:0] size_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 26'h0;
      size_q <= 3'h0;
      data_in <= 32'h0;
      wait_req_n <= 1'b1;
    end else begin
      if (!bs_n && data_oe) begin
        addr_q <= data_out[25:0];
        size_q <= data_out[31:29];
      end
      if (rd_wr && !(&cs_n) && !data_oe) data_in <= {size_q, 3'h5, addr_q};
      else data_in <= ~data_in;
      wait_req_n <= !(stall && !(&cs_n));
    end
  end
endmodule : mpx_far_model

// [tb/tb_top.sv]
// Purpose: self-checking bench for mpx_idle_ctrl
// Assumes: all idle counts 3, area 2 waits 2, DMA idle 5
// Notes: gaps allow one bus clock of slack, launches align to ticks
module tb_top
  import mpx_idle_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0, bus_release_req = 1'b0, stall = 1'b0;
  bus_req_t req = '0;
  bus_req_t r;
  logic [31:0] reg_rdata, rdata, data_in, data_out;
  logic req_ready, beat_done, rdata_valid, access_done, bus_granted, wait_req_n, bus_clock_output;
  logic data_oe, bs_n, frame_n, rd_n, rd_wr, bs_q = 1'b1, cs_q = 1'b1, be_seen = 1'b0, boot_pin = 1'b0;
  logic [25:0] addr_pins;
  logic [6:0] cs_n;
  logic [1:0] be_n;
  logic [32:0] e;
  logic [32:0] rd_q[$];
  logic [31:0] ap_q[$];
  logic [7:0] ofs[4] = '{BUS_CONTROL_ONE_OFS, BUS_CONTROL_THREE_OFS, IDLE_WAIT_CONTROL_OFS, AREA_WAIT_CONTROL_OFS};
  logic [31:0] rv[4] = '{BUS_CONTROL_ONE_RST, BUS_CONTROL_THREE_RST, IDLE_WAIT_CONTROL_RST, AREA_WAIT_CONTROL_RST};
  logic [31:0] cv[4] = '{32'h1, 32'h35, 32'h050d_b6db, 32'h80};
  int fail_count = 0, total_checks = 0, seed = 56566, gap = 0, span = 0, last_gap = 0, last_span = 0;
  int sent = 0, dones = 0, rises = 0, r0, sp_r, sp_w, beats = 0, want = 0;

  always #25 clock = ~clock;

  mpx_idle_ctrl dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req), .req_ready(req_ready), .wdata(wdata),
    .beat_done(beat_done), .rdata(rdata), .rdata_valid(rdata_valid), .access_done(access_done),
    .bus_release_req(bus_release_req), .bus_granted(bus_granted), .boot_area0_mux_select_pin(boot_pin),
    .wait_req_n(wait_req_n), .bus_clock_output(bus_clock_output), .addr_pins(addr_pins), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .bus_cycle_start_strobe_n(bs_n), .area_select_strobe_n(cs_n),
    .frame_n(frame_n), .read_strobe_n(rd_n), .byte_strobe_n(be_n), .rd_wr(rd_wr));
  mpx_far_model far_u (.clock(clock), .rst_n(rst_n), .data_out(data_out), .data_oe(data_oe), .bs_n(bs_n),
    .cs_n(cs_n), .rd_wr(rd_wr), .stall(stall), .data_in(data_in), .wait_req_n(wait_req_n));

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task chk_in(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask : chk_in

  task reg_w(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : reg_w

  task reg_r(input logic [7:0] a, input logic [31:0] x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, x);
    @(posedge clock);
  endtask : reg_r

  // Request held until taken; caller's fin drops valid
  task go(input logic w, input logic [2:0] a, input logic [2:0] s, input dma_kind_t d, input logic mux);
    int n;
    r = '0;
    r.write = w;
    r.area = a;
    r.size = s;
    r.dma = d;
    r.addr = 26'($random(seed)) & 26'h3ff_ffe0;
    if (mux) ap_q.push_back({s, 3'h0, r.addr});
    n = !mux ? 1 : (s == SIZE_QUAD) ? 2 : (s == SIZE_LINE) ? 8 : 1;
    want += n;
    if (!w) repeat (n) rd_q.push_back({!mux, s, 3'h5, r.addr});
    wdata <= $random(seed);
    req <= r;
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 4000);
    sent++;
    if (n >= 4000) begin
      fail_count++;
      stop_test;
    end
  endtask : go

  task fin;
    int n;
    req_valid <= 1'b0;
    n = 0;
    while (dones < sent && n < 4000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 4000) begin
      fail_count++;
      stop_test;
    end
  endtask : fin

  task wait_grant(input logic v);
    int k;
    k = 0;
    while (bus_granted !== v && k < 400) begin
      @(posedge clock);
      k++;
    end
    if (k >= 400) begin
      fail_count++;
      stop_test;
    end
  endtask : wait_grant

  always @(posedge clock) begin
    if (bs_q && !bs_n) chk(data_out, ap_q.pop_front());
    if (rdata_valid === 1'b1) begin
      e = rd_q.pop_front();
      if (!e[32]) chk(rdata, e[31:0]);
    end
    if (access_done === 1'b1) dones++;
    if (beat_done === 1'b1) beats++;
    if (be_n !== 2'b11) be_seen = 1'b1;
    if (&cs_n && !cs_q) begin
      last_span = span;
      gap = 0;
      rises++;
    end
    if (!(&cs_n) && cs_q) begin
      last_gap = gap;
      span = 0;
    end
    if (&cs_n) gap++;
    else span++;
    bs_q = bs_n;
    cs_q = &cs_n;
  end

  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (12) @(posedge clock);
    for (int i = 0; i < 4; i++) reg_r(ofs[i], rv[i]);
    reg_w(8'h20, 32'hffff_ffff);
    reg_r(8'h20, 32'h0);
    for (int i = 0; i < 4; i++) reg_w(ofs[i], cv[i]);
    for (int i = 0; i < 4; i++) reg_r(ofs[i], cv[i]);
    for (int s = 0; s < 5; s++) begin
      go(1'b0, 3'h0, 3'(s), DMA_NONE, 1'b1);
      fin;
      go(1'b1, 3'h0, 3'(s), DMA_NONE, 1'b1);
      fin;
    end
    go(1'b0, 3'h1, SIZE_LONG, DMA_NONE, 1'b1);
    fin;
    sp_r = last_span;
    go(1'b1, 3'h1, SIZE_LONG, DMA_NONE, 1'b1);
    fin;
    sp_w = last_span;
    chk_in(sp_r - sp_w, 8, 8);
    go(1'b0, 3'h2, SIZE_LONG, DMA_NONE, 1'b1);
    fin;
    chk_in(last_span - sp_r, 16, 16);
    stall <= 1'b1;
    go(1'b0, 3'h3, SIZE_LONG, DMA_NONE, 1'b1);
    repeat (32) @(posedge clock);
    stall <= 1'b0;
    fin;
    chk_in(last_span, sp_r + 8, sp_r + 40);
    r0 = rises;
    go(1'b1, 3'h5, SIZE_LONG, DMA_NONE, 1'b1);
    go(1'b1, 3'h5, SIZE_LONG, DMA_NONE, 1'b1);
    go(1'b1, 3'h6, SIZE_LONG, DMA_NONE, 1'b1);
    go(1'b0, 3'h6, SIZE_LONG, DMA_NONE, 1'b1);
    go(1'b0, 3'h6, SIZE_LONG, DMA_NONE, 1'b1);
    fin;
    chk_in(rises - r0, 1, 1);
    go(1'b0, 3'h1, SIZE_LONG, DMA_NONE, 1'b1);
    go(1'b1, 3'h2, SIZE_LONG, DMA_NONE, 1'b1);
    fin;
    chk_in(last_gap, 24, 32);
    go(1'b0, 3'h1, SIZE_LONG, DMA_NONE, 1'b1);
    go(1'b0, 3'h2, SIZE_LONG, DMA_NONE, 1'b1);
    fin;
    chk_in(last_gap, 24, 32);
    repeat (16) @(posedge clock);
    go(1'b1, 3'h1, SIZE_LONG, DMA_NONE, 1'b1);
    fin;
    chk_in(last_gap, 24, 32);
    go(1'b1, 3'h1, SIZE_LONG, DMA_SINGLE_IO_TO_MEM, 1'b1);
    go(1'b1, 3'h1, SIZE_LONG, DMA_SINGLE_IO_TO_MEM, 1'b1);
    fin;
    chk_in(last_gap, 40, 48);
    go(1'b0, 3'h1, SIZE_LONG, DMA_DUAL, 1'b1);
    go(1'b1, 3'h2, SIZE_LONG, DMA_DUAL, 1'b1);
    fin;
    chk_in(last_gap, 24, 32);
    be_seen = 1'b0;
    go(1'b0, 3'h4, SIZE_WORD, DMA_NONE, 1'b0);
    fin;
    chk({31'h0, be_seen}, 32'h1);
    be_seen = 1'b0;
    go(1'b1, 3'h4, SIZE_WORD, DMA_NONE, 1'b0);
    fin;
    chk({31'h0, be_seen}, 32'h1);
    go(1'b0, 3'h1, SIZE_LONG, DMA_NONE, 1'b1);
    fin;
    bus_release_req <= 1'b1;
    wait_grant(1'b1);
    chk_in(gap, 24, 400);
    bus_release_req <= 1'b0;
    wait_grant(1'b0);
    go(1'b0, 3'h0, SIZE_QUAD, DMA_NONE, 1'b1);
    fin;
    boot_pin <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (12) @(posedge clock);
    go(1'b0, 3'h0, SIZE_WORD, DMA_NONE, 1'b0);
    fin;
    chk(beats, want);
    repeat (4) @(posedge clock);
    stop_test;
  end
endmodule : tb_top
